// ==== bench/tmr_checker.sv ====
// checker: apb answer timing and register-driven pin levels of the timer
module tmr_checker import tmr_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // pins
  input wire logic osc_detach_out,
  input wire logic compare_out_a_en_out,
  input wire logic compare_out_b_en_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] && !pslverr_out;
  assign rd_ok = psel_in && penable_in && pready_out && !pwrite_in;
  a_access_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready missing after access cycle");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_error_data: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
    else $error("error answer without ready or with data");
  a_idle_data: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside answer");
  a_ctrl_rsvd: assert property (
    rd_ok && paddr_in[11:2] == TMR_IDX_CTRL_A |-> prdata_out[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_pin_take_a: assert property (
    wr_ok && paddr_in[11:2] == TMR_IDX_CTRL_A |-> ##2 compare_out_a_en_out == (|$past(pwdata_in[7:6], 2)))
    else $error("pin a enable does not follow mode");
  a_pin_take_b: assert property (
    wr_ok && paddr_in[11:2] == TMR_IDX_CTRL_A |-> ##2 compare_out_b_en_out == (|$past(pwdata_in[5:4], 2)))
    else $error("pin b enable does not follow mode");
  a_osc_detach: assert property (
    wr_ok && paddr_in[11:2] == TMR_IDX_ASYNC |-> ##2 osc_detach_out == $past(pwdata_in[TMR_ASYNC_SEL_BIT], 2))
    else $error("detach does not follow clock source");
  a_psr_zero: assert property (
    rd_ok && paddr_in[11:2] == TMR_IDX_GTC |-> prdata_out == 32'h0000_0000)
    else $error("prescaler reset bit reads nonzero");
endmodule : tmr_checker

// ==== bench/tmr_top_tb.sv ====
// testbench: registers, clock selection, prescaler reset, clock source and waveforms of the timer
module tmr_top_tb import tmr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic osc = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic detach;
  logic wa;
  logic wa_en;
  logic wb;
  logic wb_en;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  tmr_top dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .osc_in_pin_in(osc), .osc_detach_out(detach), .compare_out_a_out(wa),
    .compare_out_a_en_out(wa_en), .compare_out_b_out(wb), .compare_out_b_en_out(wb_en)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer: setup, access held until ready is sampled
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_in);
    paddr <= {idx, 2'h0};
    pwr <= wr;
    pwdata <= {24'h00_0000, d};
    psel <= 1'b1;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(idx, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [31:0] v);
    logic e;
    apb(idx, 1'b0, 8'h00, v, e);
  endtask : rd

  task automatic t_regs();
    logic [9:0] ix[6] = '{TMR_IDX_CTRL_A, TMR_IDX_CTRL_B, TMR_IDX_COUNT, TMR_IDX_CMP_A, TMR_IDX_CMP_B, TMR_IDX_ASYNC};
    logic [31:0] r;
    logic e;
    foreach (ix[i]) begin
      rd(ix[i], r);
      chk("reset value", 32'h0000_0000, r);
    end
    wr(TMR_IDX_CTRL_A, 8'hff);
    rd(TMR_IDX_CTRL_A, r);
    chk("control a", 32'h0000_00f3, r);
    pstrb <= 4'he;
    wr(TMR_IDX_CTRL_A, 8'h00);
    pstrb <= 4'hf;
    rd(TMR_IDX_CTRL_A, r);
    chk("strobeless write", 32'h0000_00f3, r);
    apb(10'h0b5, 1'b1, 8'h5a, r, e);
    chk("unmapped write error", 32'h0000_0001, e);
    apb(10'h0b5, 1'b0, 8'h00, r, e);
    chk("unmapped read error", 32'h0000_0001, e);
    chk("unmapped read data", 32'h0000_0000, r);
    wr(TMR_IDX_CTRL_A, 8'h00);
    $display("registers done");
  endtask : t_regs

  // ticks in a window of four divider periods are exactly four, whatever the phase
  task automatic t_clock_sel();
    int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [31:0] c0;
    logic [31:0] c1;
    for (int i = 0; i < 8; i++) begin
      wr(TMR_IDX_CTRL_B, 8'(i));
      rd(TMR_IDX_COUNT, c0);
      repeat ((dv[i] == 0 ? 32 : 4 * dv[i]) - 4) @(posedge clk_in);
      rd(TMR_IDX_COUNT, c1);
      chk("count step", dv[i] == 0 ? 0 : 4, 8'(c1[7:0] - c0[7:0]));
    end
    $display("clock select done");
  endtask : t_clock_sel

  task automatic t_prescale();
    logic [31:0] r;
    wr(TMR_IDX_CTRL_B, 8'h00);
    wr(TMR_IDX_COUNT, 8'h00);
    wr(TMR_IDX_GTC, 8'h02);
    wr(TMR_IDX_CTRL_B, 8'h07);
    repeat (900) @(posedge clk_in);
    rd(TMR_IDX_COUNT, r);
    chk("count before first tick", 32'h0000_0000, r);
    repeat (200) @(posedge clk_in);
    rd(TMR_IDX_COUNT, r);
    chk("count after first tick", 32'h0000_0001, r);
    rd(TMR_IDX_GTC, r);
    $display("prescaler reset done");
  endtask : t_prescale

  task automatic t_async();
    logic [31:0] c0;
    logic [31:0] c1;
    wr(TMR_IDX_CTRL_B, 8'h00);
    wr(TMR_IDX_ASYNC, 8'h08);
    repeat (2) @(negedge clk_in);
    chk("detach on", 32'h0000_0001, detach);
    wr(TMR_IDX_CTRL_B, 8'h01);
    rd(TMR_IDX_COUNT, c0);
    repeat (6) begin
      osc <= 1'b1;
      repeat (5) @(posedge clk_in);
      osc <= 1'b0;
      repeat (5) @(posedge clk_in);
    end
    rd(TMR_IDX_COUNT, c1);
    chk("oscillator ticks", 32'h0000_0006, 8'(c1[7:0] - c0[7:0]));
    wr(TMR_IDX_ASYNC, 8'h00);
    repeat (2) @(negedge clk_in);
    chk("detach off", 32'h0000_0000, detach);
    $display("clock source done");
  endtask : t_async

  // configure with the counter stopped, let it settle, then count high cycles and toggles
  task automatic wave(input logic [7:0] ca, cb, ma, mb, input int w, eha, eta, ehb, etb);
    int ha = 0;
    int ta = 0;
    int hb = 0;
    int tb = 0;
    logic pa;
    logic pb;
    wr(TMR_IDX_CTRL_B, 8'h00);
    wr(TMR_IDX_CTRL_A, 8'h00);
    wr(TMR_IDX_CMP_A, ma);
    wr(TMR_IDX_CMP_B, mb);
    wr(TMR_IDX_COUNT, 8'h00);
    wr(TMR_IDX_CTRL_A, ca);
    wr(TMR_IDX_CTRL_B, cb);
    repeat (600) @(negedge clk_in);
    pa = wa;
    pb = wb;
    repeat (w) begin
      @(negedge clk_in);
      ha += int'(wa === 1'b1);
      hb += int'(wb === 1'b1);
      ta += int'(wa !== pa);
      tb += int'(wb !== pb);
      pa = wa;
      pb = wb;
    end
    if (eha >= 0) chk("high cycles a", eha, ha);
    if (eta >= 0) chk("toggles a", eta, ta);
    if (ehb >= 0) chk("high cycles b", ehb, hb);
    if (etb >= 0) chk("toggles b", etb, tb);
  endtask : wave

  task automatic t_wave();
    logic [31:0] r;
    wave(8'h52, 8'h01, 8'h09, 8'h04, 100, -1, 10, -1, 10);
    wave(8'ha2, 8'h01, 8'h09, 8'h04, 100, 0, 0, 0, 0);
    wave(8'hf2, 8'h01, 8'h09, 8'h04, 100, 100, 0, 100, 0);
    wave(8'h50, 8'h01, 8'h09, 8'h04, 512, -1, 2, -1, 2);
    wave(8'h63, 8'h09, 8'h13, 8'h05, 200, -1, 10, 60, 20);
    wave(8'hb3, 8'h09, 8'h13, 8'h05, 200, 200, 0, 140, 20);
    wave(8'he3, 8'h09, 8'h13, 8'h05, 200, 0, 0, 60, 20);
    wave(8'h63, 8'h01, 8'h13, 8'h3f, 512, -1, 0, 128, 4);
    wave(8'h21, 8'h01, 8'h13, 8'h40, 510, -1, 0, 128, 2);
    wave(8'h50, 8'h09, 8'h09, 8'h04, 256, -1, 0, -1, 0);
    wave(8'h61, 8'h09, 8'h0a, 8'h04, 200, -1, 10, 80, 20);
    wave(8'hb1, 8'h09, 8'h0a, 8'h04, 200, 0, 0, 120, 20);
    wave(8'he1, 8'h09, 8'h0a, 8'h04, 200, 200, 0, 80, 20);
    wr(TMR_IDX_FLAG, 8'h01);
    repeat (40) @(posedge clk_in);
    rd(TMR_IDX_FLAG, r);
    chk("overflow flag", 32'h0000_0001, r);
    $display("waveforms done");
  endtask : t_wave

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_clock_sel();
    t_prescale();
    t_async();
    t_wave();
    end_of_test();
  end
endmodule : tmr_top_tb

bind tmr_top tmr_checker chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .osc_detach_out(osc_detach_out), .compare_out_a_en_out(compare_out_a_en_out),
  .compare_out_b_en_out(compare_out_b_en_out)
);

// ==== rtl/tmr_link_if.sv ====
// interface: signals shared by the counter, the prescaler and the compare channels
interface tmr_link_if;
  import tmr_pkg::*;
  logic src_tick;
  logic psr;
  logic [2:0] cs;
  logic cnt_tick;
  logic [7:0] cnt;
  logic up;
  logic [7:0] top_val;
  tmr_beh_t beh;
  logic wgm2;
  logic blk;
  logic wrap;
  logic at_top;
  modport pre_mp (input src_tick, input psr, input cs, output cnt_tick);
  modport cnt_mp (output src_tick, output psr, output cs, input cnt_tick, output cnt, output up,
                  output top_val, output beh, output wgm2, output blk, output wrap, output at_top);
  modport wave_mp (input cnt_tick, input cnt, input up, input top_val, input beh, input wgm2,
                   input blk, input wrap, input at_top);
endinterface : tmr_link_if

// ==== rtl/tmr_pkg.sv ====
// package: register indexes, field layout, reset values and mode types of the timer
package tmr_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] TMR_IDX_CTRL_A = 10'h0b0;
  localparam logic [9:0] TMR_IDX_CTRL_B = 10'h0b1;
  localparam logic [9:0] TMR_IDX_COUNT = 10'h0b2;
  localparam logic [9:0] TMR_IDX_CMP_A = 10'h0b3;
  localparam logic [9:0] TMR_IDX_CMP_B = 10'h0b4;
  localparam logic [9:0] TMR_IDX_ASYNC = 10'h0b6;
  localparam logic [9:0] TMR_IDX_GTC = 10'h0b7;
  localparam logic [9:0] TMR_IDX_FLAG = 10'h0b8;
  // reset values
  localparam logic [7:0] TMR_RST_CTRL_A = 8'h00;
  localparam logic [7:0] TMR_RST_CTRL_B = 8'h00;
  localparam logic [7:0] TMR_RST_COUNT = 8'h00;
  localparam logic [7:0] TMR_RST_CMP = 8'h00;
  // control a fields
  localparam int TMR_COM_A_LSB = 6;
  localparam int TMR_COM_B_LSB = 4;
  localparam int TMR_WGM_LSB = 0;
  localparam logic [7:0] TMR_CTRL_A_MASK = 8'hf3;
  // control b fields
  localparam int TMR_WGM2_BIT = 3;
  localparam int TMR_CS_LSB = 0;
  // own control and status bits
  localparam int TMR_ASYNC_SEL_BIT = 3;
  localparam int TMR_PSR_BIT = 1;
  localparam int TMR_OVF_BIT = 0;
  // counter landmarks
  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  // clock select codes
  localparam logic [2:0] TMR_CS_STOP = 3'h0;
  localparam logic [2:0] TMR_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR_CS_DIV32 = 3'h3;
  localparam logic [2:0] TMR_CS_DIV64 = 3'h4;
  localparam logic [2:0] TMR_CS_DIV128 = 3'h5;
  localparam logic [2:0] TMR_CS_DIV256 = 3'h6;
  // compare output mode codes
  localparam logic [1:0] TMR_COM_OFF = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;
  // waveform mode codes
  localparam logic [2:0] TMR_WGM_CLEAR = 3'h2;
  // counting behaviour decoded from the waveform mode
  typedef enum logic [2:0] {
    TMR_NORMAL,
    TMR_CLEAR_ON_MATCH,
    TMR_FAST,
    TMR_PHASE,
    TMR_HOLD
  } tmr_beh_t;
endpackage : tmr_pkg

// ==== rtl/tmr_prescaler.sv ====
// prescaler: divides the source clock and selects the count enable
module tmr_prescaler import tmr_pkg::*; #(
  parameter int unsigned PRE_W = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // link to the counter
  tmr_link_if.pre_mp lnk
);
  logic [PRE_W-1:0] pre_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= '0;
    end else if (lnk.psr) begin
      pre_q <= '0; // RULE_05
    end else if (lnk.src_tick) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // tap selection: divider ends when the low bits are all ones
  always_comb begin
    if (lnk.cs == TMR_CS_STOP) begin
      lnk.cnt_tick = 1'b0; // RULE_04
    end else if (lnk.cs == TMR_CS_DIV1) begin
      lnk.cnt_tick = lnk.src_tick; // RULE_03
    end else if (lnk.cs == TMR_CS_DIV8) begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[2:0]); // RULE_04
    end else if (lnk.cs == TMR_CS_DIV32) begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[4:0]);
    end else if (lnk.cs == TMR_CS_DIV64) begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[5:0]);
    end else if (lnk.cs == TMR_CS_DIV128) begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[6:0]);
    end else if (lnk.cs == TMR_CS_DIV256) begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[7:0]);
    end else begin
      lnk.cnt_tick = lnk.src_tick & (&pre_q[PRE_W-1:0]); // RULE_03
    end
  end
endmodule : tmr_prescaler

// ==== rtl/tmr_top.sv ====
// top: apb registers, clock source, counter and pin control of the timer
// Function
// RULE_01: io clock default, oscillator when async selected
// RULE_02: async select detaches both oscillator pins
// RULE_03: stop, undivided, or divide 8..1024
// RULE_04: clock select codes decode in ascending order
// RULE_05: prescaler reset bit restarts division phase
// RULE_06: nonzero compare mode takes over pin
// RULE_07: channel a non-pwm: off, toggle, clear, set
// RULE_08: channel a fast pwm: clear/set, toggle with bit2
// RULE_09: fast pwm compare at top acts at bottom
// RULE_10: channel a phase pwm: up/down opposite actions
// RULE_11: channel b non-pwm same encoding as a
// RULE_12: channel b fast pwm clear/set, 01 reserved
// RULE_13: channel b phase pwm, 01 reserved
// RULE_14: phase pwm compare at top acts at top
// RULE_15: control a bits 3,2 read zero
// RULE_16: two low mode bits plus third bit
// RULE_17: mode table sets sequence and top source
// RULE_18: four behaviours, max is 0xff
// RULE_19: compare update point and overflow point per mode
// RULE_20: phase pwm overflow at bottom reversal
//
// The APB register port was decided locally.
module tmr_top import tmr_pkg::*; #(
  parameter int unsigned PRE_W = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // oscillator pins
  input wire logic osc_in_pin_in,
  output logic osc_detach_out,
  // compare outputs
  output logic compare_out_a_out,
  output logic compare_out_a_en_out,
  output logic compare_out_b_out,
  output logic compare_out_b_en_out
);
  tmr_link_if lnk ();

  logic rst_s1_q;
  logic rst_n_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic [7:0] ctrl_a_q;
  logic wgm2_q;
  logic [2:0] cs_q;
  logic [7:0] cnt_q;
  logic up_q;
  logic [7:0] cmp_a_buf_q;
  logic [7:0] cmp_b_buf_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic async_clock_select_q;
  logic psr_q;
  logic ovf_q;
  logic blk_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic en_a_q;
  logic en_b_q;
  logic wave_a;
  logic wave_b;
  logic [2:0] wgm;
  tmr_beh_t beh;
  logic [7:0] top_val;
  logic tick;
  logic wrap;
  logic at_top;
  logic at_bot;
  logic ovf_set;
  logic acc;
  logic done;
  logic wr;
  logic hit;
  logic [7:0] rd_byte;
  logic [9:0] idx;
  logic [7:0] wb;

  // reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // oscillator pin synchroniser and edge detect
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_in_pin_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // source clock: io clock every cycle, or oscillator rising edge
  assign lnk.src_tick = async_clock_select_q ? (osc_s2_q & ~osc_s3_q) : 1'b1; // RULE_01
  assign lnk.psr = psr_q;
  assign lnk.cs = cs_q;
  assign tick = lnk.cnt_tick;

  tmr_prescaler #(
    .PRE_W(PRE_W)
  ) u_pre (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .lnk(lnk.pre_mp)
  );

  // waveform mode decode
  assign wgm = {wgm2_q, ctrl_a_q[TMR_WGM_LSB+1:TMR_WGM_LSB]}; // RULE_16
  always_comb begin
    case (wgm)
      3'h0: beh = TMR_NORMAL; // RULE_17 RULE_18
      3'h1: beh = TMR_PHASE;
      3'h2: beh = TMR_CLEAR_ON_MATCH;
      3'h3: beh = TMR_FAST;
      3'h5: beh = TMR_PHASE;
      3'h7: beh = TMR_FAST;
      default: beh = TMR_HOLD;
    endcase
  end
  assign top_val = (wgm2_q || (wgm == TMR_WGM_CLEAR)) ? cmp_a_q : TMR_MAX; // RULE_17

  // counter landmark events
  assign wrap = tick && ((beh == TMR_FAST) || (beh == TMR_CLEAR_ON_MATCH)) && (cnt_q == top_val);
  assign at_top = tick && (beh == TMR_PHASE) && up_q && (cnt_q == top_val);
  assign at_bot = tick && (beh == TMR_PHASE) && !up_q && (cnt_q == TMR_BOTTOM);

  always_comb begin
    if (beh == TMR_FAST) begin
      ovf_set = wrap; // RULE_19
    end else if (beh == TMR_PHASE) begin
      ovf_set = at_bot; // RULE_20
    end else if ((beh == TMR_NORMAL) || (beh == TMR_CLEAR_ON_MATCH)) begin
      ovf_set = tick && (cnt_q == TMR_MAX); // RULE_19
    end else begin
      ovf_set = 1'b0;
    end
  end

  assign lnk.cnt = cnt_q;
  assign lnk.up = up_q;
  assign lnk.top_val = top_val;
  assign lnk.beh = beh;
  assign lnk.wgm2 = wgm2_q;
  assign lnk.blk = blk_q;
  assign lnk.wrap = wrap;
  assign lnk.at_top = at_top;

  tmr_wave #(
    .CHAN_A(1'b1)
  ) u_wave_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .lnk(lnk.wave_mp),
    .ocr_in(cmp_a_q),
    .com_in(ctrl_a_q[TMR_COM_A_LSB+1:TMR_COM_A_LSB]),
    .wave_out(wave_a)
  );

  tmr_wave #(
    .CHAN_A(1'b0)
  ) u_wave_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .lnk(lnk.wave_mp),
    .ocr_in(cmp_b_q),
    .com_in(ctrl_a_q[TMR_COM_B_LSB+1:TMR_COM_B_LSB]),
    .wave_out(wave_b)
  );

  // apb access decode
  assign acc = psel_in && penable_in;
  assign done = acc && pready_q;
  assign wr = done && pwrite_in && pstrb_in[0];
  assign idx = paddr_in[11:2];
  assign wb = pwdata_in[7:0];

  always_comb begin
    hit = 1'b1;
    if (idx == TMR_IDX_CTRL_A) begin
      rd_byte = ctrl_a_q & TMR_CTRL_A_MASK; // RULE_15
    end else if (idx == TMR_IDX_CTRL_B) begin
      rd_byte = {4'h0, wgm2_q, cs_q};
    end else if (idx == TMR_IDX_COUNT) begin
      rd_byte = cnt_q;
    end else if (idx == TMR_IDX_CMP_A) begin
      rd_byte = cmp_a_buf_q;
    end else if (idx == TMR_IDX_CMP_B) begin
      rd_byte = cmp_b_buf_q;
    end else if (idx == TMR_IDX_ASYNC) begin
      rd_byte = {4'h0, async_clock_select_q, 3'h0};
    end else if (idx == TMR_IDX_GTC) begin
      rd_byte = 8'h00;
    end else if (idx == TMR_IDX_FLAG) begin
      rd_byte = {7'h00, ovf_q};
    end else begin
      rd_byte = 8'h00;
      hit = 1'b0;
    end
  end

  // apb answer: one wait cycle, then ready with data
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !hit;
      prdata_q <= (acc && !pready_q && !pwrite_in) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // control registers
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_a_q <= TMR_RST_CTRL_A;
      wgm2_q <= TMR_RST_CTRL_B[TMR_WGM2_BIT];
      cs_q <= TMR_RST_CTRL_B[TMR_CS_LSB+2:TMR_CS_LSB];
      async_clock_select_q <= 1'b0;
    end else if (wr) begin
      if (idx == TMR_IDX_CTRL_A) begin
        ctrl_a_q <= wb & TMR_CTRL_A_MASK; // RULE_15
      end else if (idx == TMR_IDX_CTRL_B) begin
        wgm2_q <= wb[TMR_WGM2_BIT]; // RULE_16
        cs_q <= wb[TMR_CS_LSB+2:TMR_CS_LSB]; // RULE_04
      end else if (idx == TMR_IDX_ASYNC) begin
        async_clock_select_q <= wb[TMR_ASYNC_SEL_BIT]; // RULE_01
      end
    end
  end

  // prescaler reset strobe
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      psr_q <= 1'b0;
    end else begin
      psr_q <= wr && (idx == TMR_IDX_GTC) && wb[TMR_PSR_BIT]; // RULE_05
    end
  end

  // compare registers: buffer written by software, active copy used for matching
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmp_a_buf_q <= TMR_RST_CMP;
      cmp_b_buf_q <= TMR_RST_CMP;
    end else if (wr) begin
      if (idx == TMR_IDX_CMP_A) begin
        cmp_a_buf_q <= wb;
      end else if (idx == TMR_IDX_CMP_B) begin
        cmp_b_buf_q <= wb;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmp_a_q <= TMR_RST_CMP;
      cmp_b_q <= TMR_RST_CMP;
    end else if ((beh == TMR_FAST) || (beh == TMR_PHASE)) begin
      if ((beh == TMR_FAST) ? wrap : at_top) begin
        cmp_a_q <= cmp_a_buf_q; // RULE_19
        cmp_b_q <= cmp_b_buf_q;
      end
    end else begin
      cmp_a_q <= cmp_a_buf_q; // RULE_19
      cmp_b_q <= cmp_b_buf_q;
    end
  end

  // counter and direction; a software write wins over counting
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= TMR_RST_COUNT;
      up_q <= 1'b1;
    end else if (wr && (idx == TMR_IDX_COUNT)) begin
      cnt_q <= wb;
    end else if (tick) begin
      case (beh)
        TMR_NORMAL: begin
          cnt_q <= cnt_q + 8'h01; // RULE_18
          up_q <= 1'b1;
        end
        TMR_CLEAR_ON_MATCH, TMR_FAST: begin
          cnt_q <= wrap ? TMR_BOTTOM : cnt_q + 8'h01; // RULE_17
          up_q <= 1'b1;
        end
        TMR_PHASE: begin
          if (at_top) begin
            up_q <= 1'b0;
            cnt_q <= cnt_q - 8'h01;
          end else if (at_bot) begin
            up_q <= 1'b1;
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= up_q ? cnt_q + 8'h01 : cnt_q - 8'h01;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // count write blocks the compare match on the following timer clock
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      blk_q <= 1'b0;
    end else if (wr && (idx == TMR_IDX_COUNT)) begin
      blk_q <= 1'b1;
    end else if (tick) begin
      blk_q <= 1'b0;
    end
  end

  // overflow flag: write one to clear, a set in the same cycle wins
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1; // RULE_19 RULE_20
    end else if (wr && (idx == TMR_IDX_FLAG) && wb[TMR_OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  // pin override enables
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
    end else begin
      en_a_q <= ctrl_a_q[TMR_COM_A_LSB+1:TMR_COM_A_LSB] != TMR_COM_OFF; // RULE_06
      en_b_q <= ctrl_a_q[TMR_COM_B_LSB+1:TMR_COM_B_LSB] != TMR_COM_OFF; // RULE_06
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign osc_detach_out = async_clock_select_q; // RULE_02
  assign compare_out_a_out = wave_a;
  assign compare_out_a_en_out = en_a_q;
  assign compare_out_b_out = wave_b;
  assign compare_out_b_en_out = en_b_q;
endmodule : tmr_top

// ==== rtl/tmr_wave.sv ====
// compare channel: match detection and output waveform of one channel
module tmr_wave import tmr_pkg::*; #(
  parameter bit CHAN_A = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // counter state
  tmr_link_if.wave_mp lnk,
  // channel configuration
  input wire logic [7:0] ocr_in,
  input wire logic [1:0] com_in,
  // waveform
  output logic wave_out
);
  logic pin_q;
  logic pin_d;
  logic match;
  logic spec;
  logic tog_ok;

  assign wave_out = pin_q;

  always_comb begin
    pin_d = pin_q;
    match = (lnk.cnt == ocr_in) && !lnk.blk;
    spec = com_in[1] && (ocr_in == lnk.top_val);
    tog_ok = lnk.wgm2 && CHAN_A;
    if (lnk.cnt_tick) begin
      case (lnk.beh)
        TMR_NORMAL, TMR_CLEAR_ON_MATCH: begin
          if (match) begin
            if (com_in == TMR_COM_TOGGLE) begin
              pin_d = ~pin_q; // RULE_07 RULE_11
            end else if (com_in == TMR_COM_CLEAR) begin
              pin_d = 1'b0;
            end else if (com_in == TMR_COM_SET) begin
              pin_d = 1'b1;
            end
          end
        end
        TMR_FAST: begin
          if (com_in == TMR_COM_TOGGLE) begin
            if (tog_ok && match) begin
              pin_d = ~pin_q; // RULE_08
            end
          end else if (com_in[1]) begin
            if (lnk.wrap) begin
              pin_d = ~com_in[0]; // RULE_08 RULE_12 RULE_09
            end else if (match && !spec) begin
              pin_d = com_in[0];
            end
          end
        end
        TMR_PHASE: begin
          if (com_in == TMR_COM_TOGGLE) begin
            if (tog_ok && match) begin
              pin_d = ~pin_q; // RULE_10
            end
          end else if (com_in[1]) begin
            if (spec) begin
              if (lnk.at_top) begin
                pin_d = com_in[0]; // RULE_14
              end
            end else if (match) begin
              pin_d = lnk.up ? com_in[0] : ~com_in[0]; // RULE_10 RULE_13
            end
          end
        end
        default: begin
          pin_d = pin_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end
endmodule : tmr_wave
